// *** core/ueb_device.sv ***
// Device end: buffer control word, endpoint engine and its Avalon-MM register slave.
//
// Local design decisions: the placing of the registers and the Avalon-MM register port.
module ueb_device #(
  parameter int RAM_AW  = 10,
  parameter int ACK_TMO = ueb_pkg::ACK_TIMEOUT_CYC
) (
  // Clock and reset
  input  wire logic              clk_in,
  input  wire logic              rstn_in,
  // Avalon-MM slave
  input  wire logic [RAM_AW+3:0] avs_address_in,
  input  wire logic              avs_read_in,
  input  wire logic              avs_write_in,
  input  wire logic [31:0]       avs_writedata_in,
  output logic      [31:0]       avs_readdata_out,
  output logic                   avs_waitrequest_out,
  // Setup interrupt
  output logic                   irq_out,
  // Link
  ueb_link_if.dev                link
);
  import ueb_pkg::*;
  localparam int AW        = RAM_AW + 4;
  localparam int RAM_BYTES = 1 << RAM_AW;

  if (RAM_AW < 7 || RAM_AW > 15)
    $error("RAM_AW must lie between 7 and 15");
  if (ACK_TMO < 1 || ACK_TMO > 65535)
    $error("ACK_TMO must lie between 1 and 65535");

  typedef enum {S_IDLE, S_SETUP, S_DATA, S_ACK, S_STATUS} ueb_dstate_e;

  function automatic logic [HALF_W-1:0] half_of(input logic [31:0] w, input logic hi);
    return hi ? w[HALF_W +: HALF_W] : w[HALF_W-1:0];
  endfunction

  function automatic logic [RAM_AW-1:0] buf_start(input logic [15:0] cfg, input logic [1:0] ofs,
                                                  input logic hi);
    logic [15:0] a;
    a = '0;
    a[BASE_MSB:BASE_LSB] = cfg[BASE_MSB:BASE_LSB];
    if (hi)
      a = a + (cfg[CFG_ISO] ? iso_gap(ofs) : BUF_BYTES);
    return a[RAM_AW-1:0];
  endfunction

  logic [7:0]        ram_q [RAM_BYTES];
  logic              ram_we;
  logic [RAM_AW-1:0] ram_wa;
  logic [7:0]        ram_wd;
  logic              ack_q;
  logic              ack_d;
  logic [31:0]       rdata_q;
  logic [31:0]       rdata_d;
  logic              acc_req;
  logic              bus_wr;
  logic              reg_hit;
  logic              ram_hit;
  logic [RAM_AW-1:0] ram_idx;
  ueb_dstate_e       state_q;
  ueb_dstate_e       state_d;
  logic [31:0]       bctl_q;
  logic [31:0]       bctl_d;
  logic [15:0]       cfg_q;
  logic [15:0]       cfg_d;
  logic [ST_W-1:0]   stat_q;
  logic [ST_W-1:0]   stat_d;
  logic [1:0]        gate_q;
  logic [1:0]        gate_d;
  logic              interrupt_enable_reg_q;
  logic              interrupt_enable_reg_d;
  logic              sel_q;
  logic              sel_d;
  logic              half_q;
  logic              half_d;
  logic [LEN_W-1:0]  cnt_q;
  logic [LEN_W-1:0]  cnt_d;
  logic [15:0]       tmr_q;
  logic [15:0]       tmr_d;
  logic              txv_q;
  logic              txv_d;
  ueb_kind_e         txk_q;
  ueb_kind_e         txk_d;
  logic [7:0]        txb_q;
  logic [7:0]        txb_d;
  logic              txl_q;
  logic              txl_d;
  logic              txp_q;
  logic              txp_d;
  logic [HALF_W-1:0] cur;
  logic [HALF_W-1:0] nxt_half;
  logic              sel_e;
  logic [RAM_AW-1:0] rd_a;

  assign acc_req             = avs_read_in | avs_write_in;
  assign avs_waitrequest_out = acc_req & ~ack_q;
  assign bus_wr              = avs_write_in & ack_q;
  assign reg_hit             = avs_address_in[AW-1:5] == '0;
  assign ram_hit             = avs_address_in[AW-1:RAM_AW+2] == RAM_WINDOW;
  assign ram_idx             = avs_address_in[RAM_AW+1:2];
  assign avs_readdata_out    = rdata_q;
  // The setup flag, masked by the interrupt enable, drives the interrupt line.
  assign irq_out             = stat_q[ST_SETUP] & interrupt_enable_reg_q;
  assign link.d2h_valid      = txv_q;
  assign link.d2h_kind       = txk_q;
  assign link.d2h_byte       = txb_q;
  assign link.d2h_last       = txl_q;
  assign link.d2h_pid        = txp_q;

  // Read data is captured on the wait cycle, so it stands at the edge where waitrequest is low.
  always_comb
  begin
    ack_d   = acc_req & ~ack_q;
    rdata_d = rdata_q;
    if (avs_read_in & ~ack_q)
    begin
      rdata_d = '0;
      if (reg_hit)
        case (avs_address_in[4:0])
          A_BUF_CTRL:   rdata_d = bctl_q;
          A_EP_CFG:     rdata_d[15:0] = cfg_q;
          A_STATUS:     rdata_d[ST_W-1:0] = stat_q;
          A_STALL_GATE: rdata_d[1:0] = gate_q;
          A_INT_EN:     rdata_d[0] = interrupt_enable_reg_q;
          default:      rdata_d = '0;
        endcase
      else if (ram_hit)
        rdata_d[7:0] = ram_q[ram_idx];
    end
  end

  always_ff @(posedge clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      ack_q   <= 1'b0;
      rdata_q <= '0;
    end
    else
    begin
      ack_q   <= ack_d;
      rdata_q <= rdata_d;
    end
  end

  // A single buffered endpoint always works on the lower half.
  assign sel_e = cfg_q[CFG_DOUBLE] & ~bctl_q[F_RSTSEL] & sel_q;
  assign cur   = half_of(bctl_q, half_q);
  assign nxt_half = half_of(bctl_q, sel_e);
  assign rd_a  = buf_start(cfg_q, bctl_q[F_ISOOFS +: 2], half_q) + RAM_AW'(cnt_q);

  always_comb
  begin
    state_d = state_q;
    bctl_d  = bctl_q;
    cfg_d   = cfg_q;
    stat_d  = stat_q;
    gate_d  = gate_q;
    interrupt_enable_reg_d  = interrupt_enable_reg_q;
    sel_d   = sel_q;
    half_d  = half_q;
    cnt_d   = cnt_q;
    tmr_d   = tmr_q;
    txv_d   = 1'b0;
    txk_d   = txk_q;
    txb_d   = txb_q;
    txl_d   = 1'b0;
    txp_d   = txp_q;
    ram_we  = 1'b0;
    ram_wa  = '0;
    ram_wd  = avs_writedata_in[7:0];
    if (bus_wr && reg_hit)
      case (avs_address_in[4:0])
        A_BUF_CTRL:   bctl_d = avs_writedata_in;
        A_EP_CFG:     cfg_d = avs_writedata_in[15:0];
        A_STATUS:     stat_d = stat_q & ~avs_writedata_in[ST_W-1:0];
        A_STALL_GATE: gate_d = avs_writedata_in[1:0];
        A_INT_EN:     interrupt_enable_reg_d = avs_writedata_in[0];
        default:      ;
      endcase
    else if (bus_wr && ram_hit)
    begin
      ram_we = 1'b1;
      ram_wa = ram_idx;
    end
    // Engine updates come after software writes so that hardware-set flags win.
    case (state_q)
      S_IDLE:
        if (link.h2d_valid && link.h2d_kind == K_SETUP)
        begin
          state_d = S_SETUP;
          cnt_d   = '0;
          gate_d  = '0;
        end
        else if (link.h2d_valid && link.h2d_kind == K_IN)
        begin
          sel_d  = sel_e;
          half_d = sel_e;
          cnt_d  = '0;
          if (bctl_q[F_STALL] && (!cfg_q[CFG_EP0] || gate_q[0]))
          begin
            txv_d = 1'b1;
            txk_d = K_STALL;
          end
          else if (nxt_half[F_AVAIL] && nxt_half[F_FULL])
            state_d = S_DATA;
          else if (!cfg_q[CFG_ISO])
          begin
            txv_d = 1'b1;
            txk_d = K_NAK;
          end
        end
      S_SETUP:
        if (link.h2d_valid)
        begin
          if (link.h2d_kind != K_DATA || cnt_q > LEN_W'(SETUP_LAST))
            state_d = S_IDLE;
          else
          begin
            ram_we = 1'b1;
            ram_wa = RAM_AW'(cnt_q);
            ram_wd = link.h2d_byte;
            cnt_d  = cnt_q + 1'b1;
            if (link.h2d_last)
            begin
              state_d = S_IDLE;
              if (cnt_q == LEN_W'(SETUP_LAST))
              begin
                txv_d            = 1'b1;
                txk_d            = K_ACK;
                stat_d[ST_SETUP] = 1'b1;
              end
            end
          end
        end
      S_DATA:
      begin
        txv_d = 1'b1;
        txp_d = cur[F_PID];
        txb_d = ram_q[rd_a];
        txk_d = (cur[LEN_W-1:0] == '0) ? K_ZLP : K_DATA;
        cnt_d = cnt_q + 1'b1;
        tmr_d = '0;
        if (cur[LEN_W-1:0] == '0 || cnt_q == cur[LEN_W-1:0] - 1'b1)
        begin
          txl_d   = 1'b1;
          state_d = cfg_q[CFG_ISO] ? S_IDLE : S_ACK;
        end
      end
      S_ACK:
        if (link.h2d_valid && link.h2d_kind == K_ACK)
          state_d = S_STATUS;
        else if (tmr_q == 16'(ACK_TMO - 1))
        begin
          stat_d[ST_TMO] = 1'b1;
          state_d        = S_IDLE;
        end
        else
          tmr_d = tmr_q + 1'b1;
      S_STATUS:
      begin
        state_d = S_IDLE;
        if (cur[F_LAST])
          stat_d[ST_XFER] = 1'b1;
        if (cfg_q[CFG_DOUBLE])
          sel_d = ~half_q;
        stat_d[half_q ? ST_BUF1 : ST_BUF0] = 1'b1;
        // Full cleared, available cleared; the iso offset code is kept as configuration.
        if (half_q)
          bctl_d[31:16] = {1'b0, cur[F_LAST], cur[F_PID], bctl_q[F_ISOOFS +: 2], 1'b0, cur[LEN_W-1:0]};
        else
          bctl_d[15:0] = {1'b0, cur[F_LAST], cur[F_PID], 3'h0, cur[LEN_W-1:0]};
        bctl_d[F_RSTSEL] = 1'b0;
      end
      default:
        state_d = S_IDLE;
    endcase
  end

  always_ff @(posedge clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      state_q <= S_IDLE;
      bctl_q  <= '0;
      cfg_q   <= '0;
      stat_q  <= '0;
      gate_q  <= '0;
      interrupt_enable_reg_q  <= 1'b0;
      sel_q   <= 1'b0;
      half_q  <= 1'b0;
      cnt_q   <= '0;
      tmr_q   <= '0;
      txv_q   <= 1'b0;
      txk_q   <= K_ACK;
      txb_q   <= '0;
      txl_q   <= 1'b0;
      txp_q   <= 1'b0;
      for (int i = 0; i < RAM_BYTES; i++)
        ram_q[i] <= '0;
    end
    else
    begin
      state_q <= state_d;
      bctl_q  <= bctl_d;
      cfg_q   <= cfg_d;
      stat_q  <= stat_d;
      gate_q  <= gate_d;
      interrupt_enable_reg_q  <= interrupt_enable_reg_d;
      sel_q   <= sel_d;
      half_q  <= half_d;
      cnt_q   <= cnt_d;
      tmr_q   <= tmr_d;
      txv_q   <= txv_d;
      txk_q   <= txk_d;
      txb_q   <= txb_d;
      txl_q   <= txl_d;
      txp_q   <= txp_d;
      if (ram_we)
        ram_q[ram_wa] <= ram_wd;
    end
  end
endmodule

// *** core/ueb_host.sv ***
// Host end: issues SETUP and IN transactions and keeps its own buffer control word.
module ueb_host #(
  parameter int RSP_TMO = ueb_pkg::ACK_TIMEOUT_CYC
) (
  // Clock and reset
  input  wire logic        clk_in,
  input  wire logic        rstn_in,
  // Link
  ueb_link_if.hst          link,
  // Command
  input  wire logic        go_in,
  input  wire logic        setup_in,
  input  wire logic        iso_in,
  input  wire logic        ack_en_in,
  input  wire logic [63:0] setup_data_in,
  input  wire logic [31:0] bctl_in,
  // Result
  output logic             busy_out,
  output logic             done_out,
  output ueb_pkg::ueb_res_e result_out,
  output logic [31:0]      bctl_out,
  output logic             rx_valid_out,
  output logic [7:0]       rx_byte_out
);
  import ueb_pkg::*;

  if (RSP_TMO < 1 || RSP_TMO > 65535)
    $error("RSP_TMO must lie between 1 and 65535");

  typedef enum {H_IDLE, H_SDATA, H_WAIT, H_RX} ueb_hstate_e;

  ueb_hstate_e      state_q;
  ueb_hstate_e      state_d;
  logic [63:0]      sbuf_q;
  logic [63:0]      sbuf_d;
  logic [31:0]      bctl_q;
  logic [31:0]      bctl_d;
  logic             iso_q;
  logic             iso_d;
  logic             acken_q;
  logic             acken_d;
  logic [LEN_W-1:0] cnt_q;
  logic [LEN_W-1:0] cnt_d;
  logic [15:0]      tmr_q;
  logic [15:0]      tmr_d;
  logic             done_q;
  logic             done_d;
  ueb_res_e         res_q;
  ueb_res_e         res_d;
  logic             rxv_q;
  logic             rxv_d;
  logic [7:0]       rxb_q;
  logic [7:0]       rxb_d;
  logic             txv_q;
  logic             txv_d;
  ueb_kind_e        txk_q;
  ueb_kind_e        txk_d;
  logic [7:0]       txb_q;
  logic [7:0]       txb_d;
  logic             txl_q;
  logic             txl_d;
  logic             beat;
  logic             is_data;

  assign busy_out       = state_q != H_IDLE;
  assign done_out       = done_q;
  assign result_out     = res_q;
  assign bctl_out       = bctl_q;
  assign rx_valid_out   = rxv_q;
  assign rx_byte_out    = rxb_q;
  assign link.h2d_valid = txv_q;
  assign link.h2d_kind  = txk_q;
  assign link.h2d_byte  = txb_q;
  assign link.h2d_last  = txl_q;
  assign beat           = link.d2h_valid;
  assign is_data        = link.d2h_kind == K_DATA;

  always_comb
  begin
    state_d = state_q;
    sbuf_d  = sbuf_q;
    bctl_d  = bctl_q;
    iso_d   = iso_q;
    acken_d = acken_q;
    cnt_d   = cnt_q;
    tmr_d   = tmr_q + 1'b1;
    done_d  = 1'b0;
    res_d   = res_q;
    rxv_d   = 1'b0;
    rxb_d   = rxb_q;
    txv_d   = 1'b0;
    txk_d   = txk_q;
    txb_d   = txb_q;
    txl_d   = 1'b0;
    case (state_q)
      H_IDLE:
        // An IN starts only when the word offers an available, empty buffer; otherwise go is ignored.
        if (go_in && (setup_in || (bctl_in[F_AVAIL] && !bctl_in[F_FULL])))
        begin
          sbuf_d  = setup_data_in;
          bctl_d  = bctl_in;
          iso_d   = iso_in;
          acken_d = ack_en_in;
          cnt_d   = '0;
          tmr_d   = '0;
          txv_d   = 1'b1;
          txk_d   = setup_in ? K_SETUP : K_IN;
          state_d = setup_in ? H_SDATA : H_WAIT;
        end
      H_SDATA:
      begin
        txv_d   = 1'b1;
        txk_d   = K_DATA;
        txb_d   = sbuf_q[8*cnt_q[2:0] +: 8];
        cnt_d   = cnt_q + 1'b1;
        tmr_d   = '0;
        if (cnt_q == LEN_W'(SETUP_LAST))
        begin
          txl_d   = 1'b1;
          state_d = H_WAIT;
        end
      end
      H_WAIT, H_RX:
        if (beat && (is_data || link.d2h_kind == K_ZLP))
        begin
          tmr_d = '0;
          rxv_d = is_data;
          rxb_d = link.d2h_byte;
          cnt_d = is_data ? cnt_q + 1'b1 : cnt_q;
          state_d = H_RX;
          if (link.d2h_last)
          begin
            txv_d   = acken_q & ~iso_q;
            txk_d   = K_ACK;
            done_d  = 1'b1;
            res_d   = RES_DATA;
            state_d = H_IDLE;
            bctl_d[HALF_W-1:0] = {1'b1, bctl_q[F_LAST], link.d2h_pid, 3'h0, cnt_d};
          end
        end
        else if (beat && state_q == H_WAIT)
        begin
          done_d  = 1'b1;
          state_d = H_IDLE;
          res_d   = (link.d2h_kind == K_ACK) ? RES_ACK : (link.d2h_kind == K_NAK) ? RES_NAK : RES_STALL;
          if (link.d2h_kind == K_STALL)
            bctl_d[F_STALL] = 1'b1;
        end
        else if (tmr_q == 16'(RSP_TMO - 1))
        begin
          done_d  = 1'b1;
          res_d   = RES_TIMEOUT;
          state_d = H_IDLE;
          if (iso_q)
            bctl_d[F_FULL] = 1'b1;
        end
      default:
        state_d = H_IDLE;
    endcase
  end

  always_ff @(posedge clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      state_q <= H_IDLE;
      sbuf_q  <= '0;
      bctl_q  <= '0;
      iso_q   <= 1'b0;
      acken_q <= 1'b0;
      cnt_q   <= '0;
      tmr_q   <= '0;
      done_q  <= 1'b0;
      res_q   <= RES_ACK;
      rxv_q   <= 1'b0;
      rxb_q   <= '0;
      txv_q   <= 1'b0;
      txk_q   <= K_IN;
      txb_q   <= '0;
      txl_q   <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      sbuf_q  <= sbuf_d;
      bctl_q  <= bctl_d;
      iso_q   <= iso_d;
      acken_q <= acken_d;
      cnt_q   <= cnt_d;
      tmr_q   <= tmr_d;
      done_q  <= done_d;
      res_q   <= res_d;
      rxv_q   <= rxv_d;
      rxb_q   <= rxb_d;
      txv_q   <= txv_d;
      txk_q   <= txk_d;
      txb_q   <= txb_d;
      txl_q   <= txl_d;
    end
  end
endmodule

// *** core/ueb_link_if.sv ***
// Packet-level link between the host end and the device end.
interface ueb_link_if;
  import ueb_pkg::*;
  logic      h2d_valid;
  ueb_kind_e h2d_kind;
  logic [7:0] h2d_byte;
  logic      h2d_last;
  logic      d2h_valid;
  ueb_kind_e d2h_kind;
  logic [7:0] d2h_byte;
  logic      d2h_last;
  logic      d2h_pid;
  modport dev (input h2d_valid, h2d_kind, h2d_byte, h2d_last,
               output d2h_valid, d2h_kind, d2h_byte, d2h_last, d2h_pid);
  modport hst (output h2d_valid, h2d_kind, h2d_byte, h2d_last,
               input d2h_valid, d2h_kind, d2h_byte, d2h_last, d2h_pid);
endinterface

// *** core/ueb_pkg.sv ***
// Shared constants and types for both ends of the endpoint buffer handshake link.
// What this block does
// - Buffer base ignores lowest six address bits.
// - Single buffered uses only lower sixteen bits.
// - Double buffered starts at 0, then alternates, except after iso transfers.
// - Buffer select is hidden internal state.
// - Host iso completion sets full despite a timeout.
// - Full bits 31/15 set and cleared.
// - Last-buffer flags at bits 30 and 14.
// - Data PID bits 29 and 13.
// - Iso second-buffer offset code at 28:27.
// - Available bits 26/10 gate buffer use.
// - Ten-bit lengths at 25:16 and 9:0.
// - Bit 12 resets select; cleared at end of acknowledged non-iso transfers.
// - Bit 11 requests STALL, or reports it.
// - Software writes available and stall last.
// - SETUP always taken into bytes 0-7, ACKed.
// - Endpoint 0 stall needs gate bit; SETUP clears gates.
// - SETUP sets flag, interrupts if enabled.
// - Stalled IN token answers STALL, back idle.
// - IN needs available and full, else NAK unless iso.
// - Data phase sends buffer, iso then idle.
// - ACK phase waits, times out with error.
// - Status phase updates flags and buffer half.
// - Config bit picks one or two 64-byte buffers.
package ueb_pkg;
  // Buffer control word fields, lower half; upper half sits HALF_W above.
  localparam int HALF_W   = 16;
  localparam int LEN_W    = 10;
  localparam int F_AVAIL  = 10;
  localparam int F_STALL  = 11;
  localparam int F_RSTSEL = 12;
  localparam int F_PID    = 13;
  localparam int F_LAST   = 14;
  localparam int F_FULL   = 15;
  localparam int F_ISOOFS = 27;
  // Endpoint configuration bits; the base field matches the endpoint control layout.
  localparam int CFG_DOUBLE = 0;
  localparam int CFG_ISO    = 1;
  localparam int CFG_EP0    = 2;
  localparam int BASE_LSB   = 6;
  localparam int BASE_MSB   = 15;
  localparam logic [15:0] BUF_BYTES   = 16'h0040;
  localparam logic [15:0] ISO_GAP_MIN = 16'h0080;
  localparam logic [3:0]  SETUP_LAST  = 4'h7;
  // Engine status bits.
  localparam int ST_W     = 5;
  localparam int ST_SETUP = 0;
  localparam int ST_XFER  = 1;
  localparam int ST_TMO   = 2;
  localparam int ST_BUF0  = 3;
  localparam int ST_BUF1  = 4;
  // Register word offsets on the bus, low five address bits.
  localparam logic [4:0] A_BUF_CTRL   = 5'h00;
  localparam logic [4:0] A_EP_CFG     = 5'h04;
  localparam logic [4:0] A_STATUS     = 5'h08;
  localparam logic [4:0] A_STALL_GATE = 5'h0C;
  localparam logic [4:0] A_INT_EN     = 5'h10;
  localparam logic [1:0] RAM_WINDOW   = 2'h1;
  // Response timeout.
  localparam int CLK_NS          = 8;
  localparam int ACK_TIMEOUT_NS  = 1500;
  localparam int ACK_TIMEOUT_CYC = ACK_TIMEOUT_NS / CLK_NS;
  typedef enum logic [2:0] {K_SETUP, K_IN, K_DATA, K_ZLP, K_ACK, K_NAK, K_STALL} ueb_kind_e;
  typedef enum logic [2:0] {RES_ACK, RES_NAK, RES_STALL, RES_DATA, RES_TIMEOUT} ueb_res_e;

  function automatic logic [15:0] iso_gap(input logic [1:0] code);
    return ISO_GAP_MIN << code;
  endfunction
endpackage

// *** verification/ueb_link_asserts.sv ***
// Concurrent checks on the packet link between the host end and the device end.
module ueb_link_asserts
  import ueb_pkg::*;
(
  // Clock and reset
  input wire logic               clk_in,
  input wire logic               rstn_in,
  // Host to device
  input wire logic               h2d_valid,
  input wire ueb_pkg::ueb_kind_e h2d_kind,
  input wire logic               h2d_last,
  // Device to host
  input wire logic               d2h_valid,
  input wire ueb_pkg::ueb_kind_e d2h_kind,
  input wire logic               d2h_last,
  input wire logic               d2h_pid
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!rstn_in);

  a_setup_acked: assert property (h2d_valid && h2d_kind == K_DATA && h2d_last |=> d2h_valid && d2h_kind == K_ACK)
    else $error("setup not acknowledged after its last byte");
  a_ack_cause: assert property (d2h_valid && d2h_kind == K_ACK |-> $past(h2d_valid && h2d_kind == K_DATA && h2d_last))
    else $error("device acknowledge without a setup packet");
  a_in_answer: assert property (h2d_valid && h2d_kind == K_IN |=> !d2h_valid || d2h_kind inside {K_DATA, K_ZLP, K_NAK, K_STALL})
    else $error("wrong answer kind to an IN token");
  a_refusal_alone: assert property (d2h_valid && d2h_kind inside {K_STALL, K_NAK} |=> !d2h_valid)
    else $error("refusal not a single beat");
  a_data_stream: assert property (d2h_valid && d2h_kind == K_DATA && !d2h_last |=> d2h_valid && d2h_kind == K_DATA && $stable(d2h_pid))
    else $error("data packet broken or its pid changed");
  a_zlp_single: assert property (d2h_valid && d2h_kind == K_ZLP |-> d2h_last ##1 !d2h_valid)
    else $error("empty packet not a single last beat");
  a_half_duplex: assert property (h2d_valid |-> !d2h_valid)
    else $error("both ends drive the link together");
  a_ack_wait: assert property (d2h_valid && d2h_kind == K_DATA && d2h_last |=> !d2h_valid [*2])
    else $error("device talks while waiting for the acknowledge");
endmodule

// *** verification/usb_endpoint_buffer_handshake_bench.sv ***
// Bench joining host and device ends; device registers are reached over Avalon-MM.
module usb_endpoint_buffer_handshake_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import ueb_pkg::*;
  localparam logic [31:0] HBC = 32'h0000_0400;
  logic        clk_in, rstn_in, av_rd, av_wr, av_wait, irq, go, setup, iso, ack_en, done, rx_valid, busy;
  logic [13:0] av_addr;
  logic [31:0] av_wdata, av_rdata, bctl, hbctl;
  logic [63:0] sdata;
  logic [7:0]  rx_byte, seed;
  ueb_res_e    result;
  int          miscompares, checked;
  logic [7:0]  exp_b[$];
  ueb_res_e    exp_r[$];

  ueb_link_if link_if ();
  ueb_device #(.ACK_TMO(20)) ueb_device_inst (.clk_in(clk_in), .rstn_in(rstn_in), .avs_address_in(av_addr),
    .avs_read_in(av_rd), .avs_write_in(av_wr), .avs_writedata_in(av_wdata), .avs_readdata_out(av_rdata),
    .avs_waitrequest_out(av_wait), .irq_out(irq), .link(link_if.dev));
  ueb_host #(.RSP_TMO(20)) ueb_host_inst (.clk_in(clk_in), .rstn_in(rstn_in), .link(link_if.hst), .go_in(go),
    .setup_in(setup), .iso_in(iso), .ack_en_in(ack_en), .setup_data_in(sdata), .bctl_in(bctl), .busy_out(busy),
    .done_out(done), .result_out(result), .bctl_out(hbctl), .rx_valid_out(rx_valid), .rx_byte_out(rx_byte));
  ueb_link_asserts ueb_link_asserts_inst (.clk_in(clk_in), .rstn_in(rstn_in), .h2d_valid(link_if.h2d_valid),
    .h2d_kind(link_if.h2d_kind), .h2d_last(link_if.h2d_last), .d2h_valid(link_if.d2h_valid),
    .d2h_kind(link_if.d2h_kind), .d2h_last(link_if.d2h_last), .d2h_pid(link_if.d2h_pid));

  initial
  begin
    clk_in = 1'b0;
    forever #4 clk_in = ~clk_in;
  end

  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e)
    begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic print_verdict();
    $display("compares %0d mismatches %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic give_up(input string nm);
    miscompares++;
    $display("[ERR] %s expected an answer seen none", nm);
    print_verdict();
  endtask

  // Request is held until waitrequest is sampled low; that edge also takes read data.
  task automatic bus(input logic w, input logic [13:0] a, input logic [31:0] d, output logic [31:0] q);
    int n;
    @(posedge clk_in);
    av_addr  <= a;
    av_wdata <= d;
    av_wr    <= w;
    av_rd    <= ~w;
    n = 0;
    do
    begin
      @(posedge clk_in);
      n++;
    end
    while (av_wait !== 1'b0 && n < 50);
    q = av_rdata;
    av_wr <= 1'b0;
    av_rd <= 1'b0;
    if (av_wait !== 1'b0)
      give_up("waitrequest");
  endtask

  task automatic wr(input logic [13:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask

  task automatic rd(input logic [13:0] a, input logic [31:0] e, input string nm);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk(nm, e, q);
  endtask

  task automatic load(input int base, input int n);
    for (int i = 0; i < n; i++)
    begin
      seed = lfsr(seed);
      exp_b.push_back(seed);
      wr(14'h1000 + 14'(4 * (base + i)), {24'h0, seed});
    end
  endtask

  task automatic xact(input logic s, input logic is, input logic [31:0] bc, input ueb_res_e r);
    int n;
    exp_r.push_back(r);
    @(posedge clk_in);
    setup <= s;
    iso   <= is;
    bctl  <= bc;
    go    <= 1'b1;
    @(posedge clk_in);
    go <= 1'b0;
    n = 0;
    do
    begin
      @(posedge clk_in);
      n++;
    end
    while (done !== 1'b1 && n < 300);
    chk("host_busy", 32'h0, {31'h0, busy});
    if (done !== 1'b1)
      give_up("done");
  endtask

  always @(posedge clk_in)
  begin
    if (rx_valid === 1'b1)
      chk("rx_byte", exp_b.pop_front(), rx_byte);
    if (done === 1'b1)
      chk("result", exp_r.pop_front(), result);
  end

  initial
  begin
    logic [63:0] sd;
    {rstn_in, av_addr, av_rd, av_wr, av_wdata, go, setup, iso, sdata, bctl} = '0;
    {ack_en, seed, miscompares, checked} = {1'b1, 8'h06, 32'h0, 32'h0};
    repeat (5) @(posedge clk_in);
    rstn_in <= 1'b1;
    rd(14'(A_BUF_CTRL), 32'h0, "bctl_reset");
    wr(14'h0014, 32'hFFFF_FFFF);
    rd(14'h0014, 32'h0, "unmapped");
    $display("test registers done");
    for (int i = 0; i < 8; i++)
    begin
      seed = lfsr(seed);
      sd[8*i+:8] = seed;
    end
    wr(14'(A_INT_EN), 32'h1);
    wr(14'(A_STALL_GATE), 32'h3);
    sdata <= sd;
    xact(1'b1, 1'b0, HBC, RES_ACK);
    for (int i = 0; i < 8; i++)
      rd(14'h1000 + 14'(4 * i), {24'h0, sd[8*i+:8]}, "setup_byte");
    rd(14'(A_STATUS), 32'h1, "setup_flag");
    chk("irq_set", 32'h1, {31'h0, irq});
    rd(14'(A_STALL_GATE), 32'h0, "gate_cleared");
    wr(14'(A_STATUS), 32'h1);
    @(posedge clk_in);
    chk("irq_clear", 32'h0, {31'h0, irq});
    $display("test setup done");
    wr(14'(A_EP_CFG), 32'h4);
    wr(14'(A_BUF_CTRL), 32'h0800);
    wr(14'(A_STALL_GATE), 32'h1);
    xact(1'b0, 1'b0, HBC, RES_STALL);
    chk("host_stall", 32'h0000_0C00, hbctl);
    wr(14'(A_STALL_GATE), 32'h0);
    xact(1'b0, 1'b0, HBC, RES_NAK);
    $display("test stall done");
    wr(14'(A_EP_CFG), 32'h40);
    wr(14'(A_STATUS), 32'h1F);
    load(64, 5);
    wr(14'(A_BUF_CTRL), 32'h0000_E405);
    xact(1'b0, 1'b0, HBC, RES_DATA);
    chk("host_word", 32'h0000_A005, hbctl);
    repeat (4) @(posedge clk_in);
    rd(14'(A_BUF_CTRL), 32'h0000_6005, "bctl_rewrite");
    rd(14'(A_STATUS), 32'h0000_000A, "status_single");
    xact(1'b0, 1'b0, HBC, RES_NAK);
    wr(14'(A_BUF_CTRL), 32'h0000_8400);
    xact(1'b0, 1'b0, HBC, RES_DATA);
    wr(14'(A_STATUS), 32'h1F);
    ack_en <= 1'b0;
    load(64, 1);
    wr(14'(A_BUF_CTRL), 32'h0000_8401);
    xact(1'b0, 1'b0, HBC, RES_DATA);
    repeat (25) @(posedge clk_in);
    rd(14'(A_STATUS), 32'h0000_0004, "ack_timeout");
    ack_en <= 1'b1;
    $display("test single done");
    wr(14'(A_EP_CFG), 32'h41);
    wr(14'(A_STATUS), 32'h1F);
    load(64, 2);
    load(128, 3);
    wr(14'(A_BUF_CTRL), 32'hA403_8402);
    xact(1'b0, 1'b0, HBC, RES_DATA);
    xact(1'b0, 1'b0, HBC, RES_DATA);
    repeat (4) @(posedge clk_in);
    rd(14'(A_BUF_CTRL), 32'h2003_0002, "bctl_double");
    rd(14'(A_STATUS), 32'h0000_0018, "status_double");
    load(64, 1);
    wr(14'(A_BUF_CTRL), 32'h0000_8401);
    xact(1'b0, 1'b0, HBC, RES_DATA);
    // The select now points at the empty upper half; only the reset-select bit brings it back.
    load(64, 1);
    wr(14'(A_BUF_CTRL), 32'h0000_9401);
    xact(1'b0, 1'b0, HBC, RES_DATA);
    repeat (4) @(posedge clk_in);
    rd(14'(A_BUF_CTRL), 32'h0000_0001, "rstsel_cleared");
    wr(14'(A_EP_CFG), 32'h43);
    load(320, 1);
    wr(14'(A_BUF_CTRL), 32'h8C01_0000);
    xact(1'b0, 1'b1, HBC, RES_DATA);
    $display("test double done");
    wr(14'(A_EP_CFG), 32'h42);
    wr(14'(A_BUF_CTRL), 32'h0);
    xact(1'b0, 1'b1, HBC, RES_TIMEOUT);
    chk("host_iso_full", 32'h0000_8400, hbctl);
    load(64, 1);
    wr(14'(A_BUF_CTRL), 32'h0000_8401);
    xact(1'b0, 1'b1, HBC, RES_DATA);
    $display("test iso done");
    print_verdict();
  end
endmodule
